// ===== rtm_pkg.sv
`default_nettype none
package rtm_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [3:0]  RTM_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  RTM_OFS_MODE    = 4'h4;
    localparam logic [3:0]  RTM_OFS_RELOAD  = 4'h8;
    localparam logic [3:0]  RTM_OFS_COUNTER = 4'hC;

    // ==========================================================
    // control register fields
    // ==========================================================
    localparam int RTM_CTRL_RUN   = 0;
    localparam int RTM_CTRL_CTS   = 1;
    localparam int RTM_CTRL_TXCLK = 2;
    localparam int RTM_CTRL_RXCLK = 3;
    localparam int RTM_CTRL_EXTEN = 4;
    localparam int RTM_CTRL_EXF   = 5;
    localparam int RTM_CTRL_OVF   = 6;

    // ==========================================================
    // mode register fields
    // ==========================================================
    localparam int RTM_MODE_CM_LO = 0;
    localparam int RTM_MODE_CM_HI = 1;
    localparam int RTM_MODE_CLKOE = 2;
    localparam int RTM_MODE_DOWN_COUNT_ENABLE  = 3;
    localparam int RTM_MODE_PS_LO = 4;
    localparam int RTM_MODE_PS_HI = 7;

    // ==========================================================
    // count modes, limits, reset values
    // ==========================================================
    localparam logic [1:0]  RTM_CM_BASE    = 2'h0;
    localparam logic [1:0]  RTM_CM_PERIOD  = 2'h1;
    localparam logic [1:0]  RTM_CM_DUAL1   = 2'h2;
    localparam logic [1:0]  RTM_CM_DUAL2   = 2'h3;
    localparam logic [15:0] RTM_CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] RTM_CNT_MIN    = 16'h0000;
    localparam logic [15:0] RTM_RST_CNT    = 16'h0000;
    localparam logic [15:0] RTM_RST_RELOAD = 16'h0000;
    localparam logic [3:0]  RTM_RST_PS     = 4'h0;
    localparam logic [3:0]  RTM_BAUD_DIV_M1 = 4'hF;   // rollovers per bit - 1

    typedef enum logic {
        RTM_DIR_UP   = 1'b0,
        RTM_DIR_DOWN = 1'b1
    } rtm_dir_e;

endpackage
`default_nettype wire

// ===== rtm_reload_timer.sv
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rtm_reload_timer (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // avalon-mm slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output var  logic [31:0]          avs_readdata,
    output var  logic                 avs_waitrequest,
    // pins
    input  wire logic                 external_trigger_pin,
    input  wire logic                 count_input_pin,
    output var  logic                 toggle_output_pin,
    // serial port clocks and interrupt request
    output var  logic                 tx_bit_tick,
    output var  logic                 rx_bit_tick,
    output var  logic                 timer_irq
);
    import rtm_pkg::*;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [1:0] pin_in;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] lvl_r;
    logic [1:0] fall;

    assign pin_in = {count_input_pin, external_trigger_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            logic agree;
            assign agree    = sync2_r[gi] == sync3_r[gi];
            assign fall[gi] = agree & lvl_r[gi] & ~sync3_r[gi];
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                    sync3_r[gi] <= 1'b1;
                    lvl_r[gi]   <= 1'b1;
                end else begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (agree) begin
                        lvl_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    logic trig_fall;
    logic trig_lvl;
    logic cnt_fall;
    assign trig_fall = fall[0];
    assign trig_lvl  = lvl_r[0];
    assign cnt_fall  = fall[1];

    // ==========================================================
    // software registers, internal counters and write decode
    // ==========================================================
    logic        run_control_r;
    logic        counter_timer_select_r;
    logic        tx_clock_select_r;
    logic        rx_clock_select_r;
    logic        external_enable_r;
    logic        overflow_flag_r;
    logic        external_flag_r;
    logic [1:0]  count_mode_select_r;
    logic        clock_out_enable_r;
    logic        down_count_enable_r;
    logic [3:0]  prescaler_value_r;
    logic [15:0] reload_r;
    logic [15:0] top_r;
    logic [15:0] cnt_r;
    logic [3:0]  ps_cnt_r;
    logic [3:0]  baud_div_r;
    rtm_dir_e    dir_r;

    logic        acc;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        wr_reload;
    logic        wr_cnt;
    assign acc       = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_ctrl   = acc & avs_write & (avs_address == RTM_OFS_CTRL);
    assign wr_mode   = acc & avs_write & (avs_address == RTM_OFS_MODE);
    assign wr_reload = acc & avs_write & (avs_address == RTM_OFS_RELOAD);
    assign wr_cnt    = acc & avs_write & (avs_address == RTM_OFS_COUNTER);

    // ==========================================================
    // mode decode
    // ==========================================================
    logic baud_mode;
    logic clk_out_mode;
    logic dual_mode;
    logic dir_pin_mode;
    logic count_up;
    logic tick;
    logic ps_done;

    assign baud_mode    = tx_clock_select_r | rx_clock_select_r;
    assign clk_out_mode = clock_out_enable_r & ~counter_timer_select_r;
    assign dual_mode    = count_mode_select_r[1];
    assign dir_pin_mode = down_count_enable_r & external_enable_r
                          & ~dual_mode;
    assign count_up     = ~dir_pin_mode | trig_lvl;
    assign ps_done      = ps_cnt_r == prescaler_value_r;
    // counter input counts pin falls, timer counts prescaled clock
    assign tick         = run_control_r & (counter_timer_select_r
                          ? cnt_fall : ps_done);

    // ==========================================================
    // counting engine
    // ==========================================================
    logic [15:0] cnt_nxt;
    logic [15:0] top_nxt;
    logic        roll;       // any overflow or underflow
    logic        ovf_set;
    logic        exf_set;
    logic        exf_tgl;
    rtm_dir_e    dir_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        top_nxt = top_r;
        dir_nxt = dir_r;
        roll    = 1'b0;
        ovf_set = 1'b0;
        exf_set = 1'b0;
        exf_tgl = 1'b0;
        if (count_mode_select_r == RTM_CM_BASE) begin
            top_nxt = reload_r;
        end
        if (tick) begin
            unique case (count_mode_select_r)
                RTM_CM_BASE: begin
                    if (count_up) begin
                        if (cnt_r == RTM_CNT_MAX) begin
                            cnt_nxt = reload_r;
                            roll    = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r + 16'h0001;
                        end
                    end else if (cnt_r == reload_r) begin
                        cnt_nxt = RTM_CNT_MAX;
                        roll    = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                    exf_tgl = roll & dir_pin_mode;
                end
                RTM_CM_PERIOD: begin
                    if (count_up) begin
                        if (cnt_r >= top_r) begin
                            cnt_nxt = RTM_CNT_MIN;
                            top_nxt = reload_r;
                            roll    = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r + 16'h0001;
                        end
                    end else if (cnt_r == RTM_CNT_MIN) begin
                        cnt_nxt = top_r;
                        roll    = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                RTM_CM_DUAL1,
                RTM_CM_DUAL2: begin
                    if (dir_r == RTM_DIR_UP) begin
                        if (cnt_r >= top_r) begin
                            dir_nxt = RTM_DIR_DOWN;
                            cnt_nxt = (cnt_r == RTM_CNT_MIN)
                                      ? cnt_r : cnt_r - 16'h0001;
                            // second flag point only in mode 11
                            roll    = count_mode_select_r[0];
                        end else begin
                            cnt_nxt = cnt_r + 16'h0001;
                        end
                    end else if (cnt_r == RTM_CNT_MIN) begin
                        dir_nxt = RTM_DIR_UP;
                        top_nxt = reload_r;
                        cnt_nxt = (reload_r == RTM_CNT_MIN)
                                  ? cnt_r : cnt_r + 16'h0001;
                        roll    = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
            endcase
        end
        // trigger falls act only when the pin is not the direction
        if (external_enable_r & trig_fall & ~dir_pin_mode & ~dual_mode) begin
            exf_set = 1'b1;
            if (!baud_mode) begin
                if (count_mode_select_r == RTM_CM_BASE) begin
                    cnt_nxt = reload_r;
                end else begin
                    cnt_nxt = RTM_CNT_MIN;
                end
            end
        end
        if (wr_cnt) begin
            cnt_nxt = avs_writedata[15:0];
        end
        ovf_set = roll & ~baud_mode;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r    <= RTM_RST_CNT;
            top_r    <= RTM_RST_RELOAD;
            dir_r    <= RTM_DIR_UP;
            ps_cnt_r <= RTM_RST_PS;
        end else begin
            cnt_r    <= cnt_nxt;
            top_r    <= top_nxt;
            dir_r    <= dir_nxt;
            ps_cnt_r <= (ps_done | ~run_control_r) ? RTM_RST_PS
                        : ps_cnt_r + 4'h1;
        end
    end

    // ==========================================================
    // control / mode / reload registers and flags
    // ==========================================================
    logic ovf_nxt;
    logic exf_nxt;

    // hardware set beats a software write in the same cycle
    assign ovf_nxt = ovf_set | (wr_ctrl ? avs_writedata[RTM_CTRL_OVF]
                                        : overflow_flag_r);
    assign exf_nxt = dual_mode ? (dir_nxt == RTM_DIR_DOWN)
                   : exf_tgl ? ~external_flag_r
                   : exf_set | (wr_ctrl ? avs_writedata[RTM_CTRL_EXF]
                                        : external_flag_r);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_control_r          <= 1'b0;
            counter_timer_select_r <= 1'b0;
            tx_clock_select_r      <= 1'b0;
            rx_clock_select_r      <= 1'b0;
            external_enable_r      <= 1'b0;
            overflow_flag_r        <= 1'b0;
            external_flag_r        <= 1'b0;
        end else begin
            overflow_flag_r        <= ovf_nxt;
            external_flag_r        <= exf_nxt;
            if (wr_ctrl) begin
                run_control_r          <= avs_writedata[RTM_CTRL_RUN];
                counter_timer_select_r <= avs_writedata[RTM_CTRL_CTS];
                tx_clock_select_r      <= avs_writedata[RTM_CTRL_TXCLK];
                rx_clock_select_r      <= avs_writedata[RTM_CTRL_RXCLK];
                external_enable_r      <= avs_writedata[RTM_CTRL_EXTEN];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_mode_select_r <= RTM_CM_BASE;
            clock_out_enable_r  <= 1'b0;
            down_count_enable_r <= 1'b0;
            prescaler_value_r   <= RTM_RST_PS;
            reload_r            <= RTM_RST_RELOAD;
        end else begin
            if (wr_mode) begin
                count_mode_select_r <=
                    avs_writedata[RTM_MODE_CM_HI:RTM_MODE_CM_LO];
                clock_out_enable_r  <= avs_writedata[RTM_MODE_CLKOE];
                down_count_enable_r <= avs_writedata[RTM_MODE_DOWN_COUNT_ENABLE];
                prescaler_value_r   <=
                    avs_writedata[RTM_MODE_PS_HI:RTM_MODE_PS_LO];
            end
            if (wr_reload) begin
                reload_r <= avs_writedata[15:0];
            end
        end
    end

    // ==========================================================
    // outputs: clock out, bit ticks, interrupt
    // ==========================================================
    logic baud_wrap;
    logic irq_nxt;
    assign baud_wrap = roll & (baud_div_r == RTM_BAUD_DIV_M1);
    // exclusions: baud and clock-out rollovers, dual-mode flag and the direction-mode flag in mode 00
    assign irq_nxt = (overflow_flag_r & ~clk_out_mode)
                   | (external_flag_r & ~dual_mode
                      & ~(dir_pin_mode
                          & (count_mode_select_r == RTM_CM_BASE)));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            toggle_output_pin <= 1'b0;
            baud_div_r        <= 4'h0;
            tx_bit_tick       <= 1'b0;
            rx_bit_tick       <= 1'b0;
            timer_irq         <= 1'b0;
        end else begin
            if (roll & clk_out_mode) begin
                toggle_output_pin <= ~toggle_output_pin;
            end
            if (roll & baud_mode) begin
                baud_div_r <= baud_div_r + 4'h1;
            end
            tx_bit_tick <= baud_wrap & tx_clock_select_r;
            rx_bit_tick <= baud_wrap & rx_clock_select_r;
            timer_irq   <= irq_nxt;
        end
    end

    // ==========================================================
    // avalon-mm slave: one wait cycle per access
    // ==========================================================
    logic [31:0] rd_mux;
    logic        req;
    assign req = avs_read | avs_write;
    assign rd_mux =
        (avs_address == RTM_OFS_CTRL) ? {25'h0,
            overflow_flag_r, external_flag_r, external_enable_r,
            rx_clock_select_r, tx_clock_select_r,
            counter_timer_select_r, run_control_r}
      : (avs_address == RTM_OFS_MODE) ? {24'h000000, prescaler_value_r,
            down_count_enable_r, clock_out_enable_r, count_mode_select_r}
      : (avs_address == RTM_OFS_RELOAD)  ? {16'h0000, reload_r}
      : (avs_address == RTM_OFS_COUNTER) ? {16'h0000, cnt_r}
      : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (req & avs_waitrequest & avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end

endmodule
`default_nettype wire

// ===== rtm_reload_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rtm_reload_timer_sva (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // event outputs
    input wire logic        tx_bit_tick,
    input wire logic        rx_bit_tick,
    input wire logic        timer_irq
);
    // ======================================================
    // bus and event checks
    // ======================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire req      = avs_read | avs_write;
    wire rd_done  = avs_read & ~avs_waitrequest;
    wire bus_done = req & ~avs_waitrequest;
    wire unmapped = avs_address[1:0] != 2'h0;

    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property ($fell(avs_waitrequest) |-> $past(req))
        else $error("waitrequest fell without a request");
    a_req_answered: assert property
        (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered on the next cycle");
    a_unmapped_zero: assert property (rd_done && unmapped |-> !avs_readdata)
        else $error("unmapped read returned nonzero data");
    a_upper_zero: assert property (rd_done |-> avs_readdata[31:16] == 16'h0)
        else $error("unused read data bits not zero");
    a_rdata_hold: assert property
        ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("read data changed outside a read");
    a_tx_pulse_gap: assert property (tx_bit_tick |=> !tx_bit_tick [*8])
        else $error("transmit bit ticks too close together");
    a_rx_pulse_gap: assert property (rx_bit_tick |=> !rx_bit_tick [*8])
        else $error("receive bit ticks too close together");
    // overflow flag clears only by software and the external flag is masked when hardware clears it, so a falling request needs a write
    a_irq_fall_cause: assert property ($fell(timer_irq) |->
        $past(bus_done) || $past(bus_done, 2) || $past(bus_done, 3))
        else $error("interrupt request dropped without a bus write");

    c_read_done: cover property (rd_done);
    c_tx_tick: cover property (tx_bit_tick);
    c_irq_rise: cover property ($rose(timer_irq));
endmodule
bind rtm_reload_timer rtm_reload_timer_sva u_rtm_reload_timer_sva (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .tx_bit_tick, .rx_bit_tick, .timer_irq
);
`default_nettype wire

// ===== rtm_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module rtm_far_side (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // pins into the timer
    input  wire logic        trig_lvl,
    input  wire logic        cnt_lvl,
    output var  logic        external_trigger_pin,
    output var  logic        count_input_pin,
    // serial port and clock-out side
    input  wire logic        tx_bit_tick,
    input  wire logic        rx_bit_tick,
    input  wire logic        toggle_output_pin,
    output var  logic [15:0] tx_seen,
    output var  logic [15:0] rx_seen,
    output var  logic [15:0] tog_seen
);
    // ======================================================
    // pins and event counters
    // ======================================================
    logic tog_r;
    // counter input idles high; the bench pulses it low
    assign count_input_pin      = cnt_lvl;
    assign external_trigger_pin = trig_lvl;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_seen  <= 16'h0;
            rx_seen  <= 16'h0;
            tog_seen <= 16'h0;
            tog_r    <= 1'b0;
        end else begin
            tx_seen  <= tx_seen + {15'h0, tx_bit_tick};
            rx_seen  <= rx_seen + {15'h0, rx_bit_tick};
            tog_seen <= tog_seen + {15'h0, toggle_output_pin ^ tog_r};
            tog_r    <= toggle_output_pin;
        end
    end
endmodule
`default_nettype wire

// ===== test_reload_timer_modes.sv
`timescale 1ns/1ps
`default_nettype none
module test_reload_timer_modes;
    import rtm_pkg::*;
    // ======================================================
    // signals and instances
    // ======================================================
    logic        ref_clk, rst_b, avs_read, avs_write, trig_lvl, cnt_lvl;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        avs_waitrequest, toggle_output_pin, timer_irq;
    logic        tx_bit_tick, rx_bit_tick;
    logic        external_trigger_pin, count_input_pin;
    logic [15:0] tx_seen, tog_seen, rx_seen;
    int          errors, comparisons;
    rtm_reload_timer u_rtm_reload_timer (
        .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest,
        .external_trigger_pin, .count_input_pin, .toggle_output_pin,
        .tx_bit_tick, .rx_bit_tick, .timer_irq);
    rtm_far_side u_rtm_far_side (
        .ref_clk, .rst_b, .trig_lvl, .external_trigger_pin,
        .count_input_pin, .tx_bit_tick, .toggle_output_pin,
        .tx_seen, .tog_seen, .cnt_lvl, .rx_bit_tick, .rx_seen);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ======================================================
    // shared tasks
    // ======================================================
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // polling latency makes some values land in a small window
    task automatic in_range(input logic [31:0] v, lo, hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    task automatic xfer(input logic wr_en, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr_en;
        avs_read      <= ~wr_en;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            give_verdict();
        end
        // idle edge keeps two transfers from touching one time step
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic wait_bit(input int b, output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0;
        while (q[b] !== 1'b1 && n < 400) begin
            rd(RTM_OFS_CTRL, q);
            n++;
        end
        if (q[b] !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask
    // ======================================================
    // scenarios
    // ======================================================
    task automatic t_reset();
        logic [31:0] q;
        rd(RTM_OFS_CTRL, q);
        check(q, 32'h0);
        rd(RTM_OFS_MODE, q);
        check(q, 32'h0);
        wr(4'h2, 32'hFF);
        rd(4'h2, q);
        check(q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_dual();
        logic [31:0] q;
        int nf;
        for (int m = 2; m < 4; m++) begin
            nf = 0;
            wr(RTM_OFS_RELOAD, 32'h3);
            wr(RTM_OFS_COUNTER, 32'h0);
            wr(RTM_OFS_MODE, 32'hF8 | m);
            wr(RTM_OFS_CTRL, 32'h11);
            repeat (200) begin
                rd(RTM_OFS_CTRL, q);
                if (q[6] === 1'b1) begin
                    nf++;
                    if (m == 2 && nf > 1) check({31'h0, q[5]}, 32'h0);
                    wr(RTM_OFS_CTRL, 32'h11);
                end
            end
            wr(RTM_OFS_CTRL, 32'h0);
            if (m == 2) in_range(nf, 5, 9);
            else in_range(nf, 11, 16);
        end
        $display("test dual done");
    endtask
    task automatic t_mode01();
        logic [31:0] q;
        wr(RTM_OFS_RELOAD, 32'h3);
        wr(RTM_OFS_COUNTER, 32'h0);
        wr(RTM_OFS_MODE, 32'hF1);
        wr(RTM_OFS_CTRL, 32'h01);
        wait_bit(6, q);
        wr(RTM_OFS_CTRL, 32'h01);
        wr(RTM_OFS_RELOAD, 32'h8000);
        wait_bit(6, q);
        wr(RTM_OFS_CTRL, 32'h0);
        rd(RTM_OFS_COUNTER, q);
        in_range(q, 0, 1);
        $display("test mode01 done");
    endtask
    task automatic t_mode00();
        logic [31:0] q, q2;
        time t0;
        wr(RTM_OFS_RELOAD, 32'h1234);
        wr(RTM_OFS_COUNTER, 32'hFFFE);
        wr(RTM_OFS_MODE, 32'hF0);
        t0 = $time;
        wr(RTM_OFS_CTRL, 32'h01);
        wait_bit(6, q);
        in_range(32'(($time - t0) / 8), 16, 52);
        check({31'h0, timer_irq}, 32'h1);
        wr(RTM_OFS_CTRL, 32'h40);
        rd(RTM_OFS_COUNTER, q);
        in_range(q, 32'h1234, 32'h1235);
        repeat (40) @(posedge ref_clk);
        rd(RTM_OFS_COUNTER, q2);
        check(q2, q);
        wr(RTM_OFS_CTRL, 32'h0);
        $display("test mode00 done");
    endtask
    task automatic t_trig();
        logic [31:0] q;
        for (int m = 0; m < 2; m++) begin
            wr(RTM_OFS_RELOAD, 32'h5555);
            wr(RTM_OFS_COUNTER, 32'h0100);
            wr(RTM_OFS_MODE, 32'hF0 | m);
            wr(RTM_OFS_CTRL, 32'h11);
            trig_lvl <= 1'b0;
            wait_bit(5, q);
            wr(RTM_OFS_CTRL, 32'h0);
            rd(RTM_OFS_COUNTER, q);
            in_range(q, m ? 0 : 32'h5555, m ? 1 : 32'h5556);
            trig_lvl <= 1'b1;
            repeat (8) @(posedge ref_clk);
        end
        $display("test trigger done");
    endtask
    task automatic t_updown();
        logic [31:0] q;
        trig_lvl <= 1'b0;
        wr(RTM_OFS_RELOAD, 32'h1000);
        wr(RTM_OFS_COUNTER, 32'h1001);
        wr(RTM_OFS_MODE, 32'hF8);
        wr(RTM_OFS_CTRL, 32'h11);
        wait_bit(6, q);
        check({31'h0, q[5]}, 32'h1);
        wr(RTM_OFS_CTRL, 32'h30);
        rd(RTM_OFS_COUNTER, q);
        in_range(q, 32'hFFFE, 32'hFFFF);
        check({31'h0, timer_irq}, 32'h0);
        wr(RTM_OFS_CTRL, 32'h0);
        trig_lvl <= 1'b1;
        $display("test updown done");
    endtask
    task automatic t_baud();
        logic [31:0] q;
        logic [15:0] tx0, tg0, rx0;
        wr(RTM_OFS_RELOAD, 32'hFFFC);
        wr(RTM_OFS_COUNTER, 32'hFFFC);
        wr(RTM_OFS_MODE, 32'h04);
        tx0 = tx_seen;
        tg0 = tog_seen;
        rx0 = rx_seen;
        wr(RTM_OFS_CTRL, 32'h0D);
        repeat (640) @(posedge ref_clk);
        wr(RTM_OFS_CTRL, 32'h0C);
        in_range(tog_seen - tg0, 158, 163);
        in_range(tx_seen - tx0, 9, 11);
        in_range(rx_seen - rx0, 9, 11);
        rd(RTM_OFS_CTRL, q);
        check(q, 32'h0C);
        check({31'h0, timer_irq}, 32'h0);
        // clock out alone: flag sets, but no interrupt
        wr(RTM_OFS_CTRL, 32'h01);
        wait_bit(6, q);
        check({31'h0, timer_irq}, 32'h0);
        wr(RTM_OFS_CTRL, 32'h0);
        $display("test baud done");
    endtask
    task automatic t_count();
        logic [31:0] q;
        wr(RTM_OFS_COUNTER, 32'h0);
        wr(RTM_OFS_CTRL, 32'h03);
        repeat (10) begin
            cnt_lvl <= ~cnt_lvl;
            repeat (8) @(posedge ref_clk);
        end
        wr(RTM_OFS_CTRL, 32'h0);
        rd(RTM_OFS_COUNTER, q);
        check(q, 32'h5);
        $display("test count done");
    endtask
    initial begin
        errors = 0;
        comparisons = 0;
        rst_b = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        trig_lvl = 1'b1;
        cnt_lvl = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_dual();
        t_mode01();
        t_mode00();
        t_trig();
        t_updown();
        t_baud();
        t_count();
        give_verdict();
    end
endmodule
`default_nettype wire
